/* File: flash_host_bus_interface.sv */
`timescale 1ns/1ns
module flash_host_bus_interface
  import flash_bus_pkg::*;
(
  input  wire logic              clock_in,           // System clock
  input  wire logic              rstn_in,            // Reset pin, low
  // Host pins
  input  wire logic [ADDR_W-1:0] addr_pin_in,        // Word address
  input  wire logic [DATA_W-1:0] dq_in,              // Data pin level
  output logic      [DATA_W-1:0] dq_out,             // Data drive value
  output logic      [DATA_W-1:0] dq_oe_out,          // Data drive enable
  input  wire logic              chip_sel_n_in,      // Chip select
  input  wire logic              out_en_n_in,        // Output enable
  input  wire logic              write_en_n_in,      // Write strobe
  input  wire logic              address_valid_n_in, // Address valid
  input  wire logic              bus_clk_in,         // Host bus clock
  output logic                   wait_out,           // Wait level
  output logic                   wait_oe_out,        // Wait enable
  // Configuration from the command logic
  input  wire logic [1:0]        density_in,         // Part density
  input  wire logic              cfg_load_in,        // Config write
  input  wire logic [CFG_W-1:0]  cfg_data_in,        // Config value
  output logic      [CFG_W-1:0]  read_config_reg_out, // Config now
  // Array side
  output logic      [ADDR_W-1:0] array_addr_out,     // Latched address
  output logic                   upper_die_out,      // Upper die chosen
  output logic                   array_active_out,   // Die selected
  input  wire logic [DATA_W-1:0] rd_data_in,         // Array read data
  input  wire logic              rd_valid_in,        // Read data ready
  output logic                   wr_valid_out,       // Write word ready
  output logic      [ADDR_W-1:0] wr_addr_out,        // Write address
  output logic      [DATA_W-1:0] wr_data_out,        // Write data
  input  wire logic              wr_ready_in,        // Core takes word
  input  wire logic              overrun_clr_in,     // Clear overrun
  output logic                   overrun_out         // Write was lost
);

  // ****************************************
  // Function
  // ****************************************
  // Address pins that exist for a density; others read as zero
  function automatic logic [ADDR_W-1:0] dens_mask(input logic [1:0] d);
    logic [ADDR_W-1:0] m;
    m = MASK_64M;
    unique case (density_t'(d))
      DENS_64M:  m = MASK_64M;
      DENS_128M: m = MASK_128M;
      DENS_256M: m = MASK_256M;
      DENS_512M: m = MASK_512M;
    endcase
    return m;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pin_raw, s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;

  assign pin_raw = {addr_pin_in, dq_in, chip_sel_n_in, out_en_n_in,
                    write_en_n_in, address_valid_n_in, bus_clk_in};

  // A bit moves only when stages two and three agree
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  // Three stages, then the filtered value and its last copy
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q   <= PIN_RESET;
      s2_q   <= PIN_RESET;
      s3_q   <= PIN_RESET;
      filt_q <= PIN_RESET;
      prev_q <= PIN_RESET;
    end else begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  // ****************************************
  // Decoded pin levels and edges
  // ****************************************
  logic              cs_n, oe_n, avalid_n, avalid_rise, avalid_fall;
  logic              we_rise, clk_rise, sync_mode, selected, reading;
  logic [ADDR_W-1:0] pin_addr;
  logic [DATA_W-1:0] pin_data;
  logic [CFG_W-1:0]  cfg_q, cfg_d;

  assign cs_n      = filt_q[P_CS];
  assign oe_n      = filt_q[P_OE];
  assign avalid_n    = filt_q[P_AVALID];
  assign avalid_rise = avalid_n && !prev_q[P_AVALID];
  assign avalid_fall = !avalid_n && prev_q[P_AVALID];
  assign we_rise   = filt_q[P_WE] && !prev_q[P_WE];
  assign clk_rise  = filt_q[P_CLK] && !prev_q[P_CLK];
  // Lowest pin is a word address bit; no byte lane below it
  assign pin_addr  = filt_q[P_ADR_LO +: ADDR_W]
                     & dens_mask(density_in);
  assign pin_data  = filt_q[P_DQ_LO +: DATA_W];
  assign sync_mode = cfg_q[CFG_SYNC_BIT];
  assign selected  = !cs_n;
  assign reading   = selected && !oe_n && filt_q[P_WE];

  // ****************************************
  // Read configuration
  // ****************************************
  // Reset leaves the config in asynchronous array read
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_load_in) begin
      cfg_d = cfg_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************
  // Address latch
  // ****************************************
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              captured_q, captured_d;
  logic              die_q, die_d, active_q, active_d;

  always_comb begin
    addr_d     = addr_q;
    captured_d = captured_q;
    if (sync_mode) begin
      // First of valid rise or bus clock edge wins; a new cycle
      // starts when address valid falls again
      if (avalid_fall) begin
        captured_d = 1'b0;
      end
      if ((!captured_q || avalid_fall)
          && (avalid_rise || (clk_rise && !avalid_n))) begin
        addr_d     = pin_addr;
        captured_d = 1'b1;
      end
    end else begin
      // Flow through while valid is low, hold after it rises
      captured_d = 1'b0;
      if (!avalid_n || avalid_rise) begin
        addr_d = pin_addr;
      end
    end
    die_d    = (density_t'(density_in) == DENS_512M)
               && addr_d[DIE_BIT];
    active_d = selected;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_q     <= '0;
      captured_q <= 1'b0;
      die_q      <= 1'b0;
      active_q   <= 1'b0;
    end else begin
      addr_q     <= addr_d;
      captured_q <= captured_d;
      die_q      <= die_d;
      active_q   <= active_d;
    end
  end

  // ****************************************
  // Output drivers and wait
  // ****************************************
  logic [DATA_W-1:0] dq_q, dq_d, dq_oe_q, dq_oe_d;
  logic              wait_q, wait_d, wait_oe_q, wait_oe_d, wait_act;

  always_comb begin
    dq_d    = dq_q;
    if (reading) begin
      dq_d = rd_data_in;
    end
    // Released whenever select or output enable is high
    dq_oe_d   = reading ? '1 : '0;
    wait_oe_d = selected && !oe_n;
    // Only a sync read may flag data not yet valid
    wait_act  = reading && sync_mode && !rd_valid_in;
    wait_d    = wait_act ~^ cfg_q[CFG_WAIT_POL_BIT];
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dq_q      <= '0;
      dq_oe_q   <= '0;
      wait_q    <= 1'b0;
      wait_oe_q <= 1'b0;
    end else begin
      dq_q      <= dq_d;
      dq_oe_q   <= dq_oe_d;
      wait_q    <= wait_d;
      wait_oe_q <= wait_oe_d;
    end
  end

  // ****************************************
  // Write capture
  // ****************************************
  wr_stream_if       wr_if ();
  logic              pend_q, pend_d, ovr_q, ovr_d;
  logic [ADDR_W-1:0] pend_a_q, pend_a_d;
  logic [DATA_W-1:0] pend_w_q, pend_w_d;
  logic              new_wr;

  // A held word waits for buffer room; the host cannot be stalled,
  // so a strobe arriving meanwhile is dropped and flagged
  always_comb begin
    new_wr   = we_rise && selected;
    pend_d   = pend_q;
    pend_a_d = pend_a_q;
    pend_w_d = pend_w_q;
    ovr_d    = ovr_q;
    if (overrun_clr_in) begin
      ovr_d = 1'b0;
    end
    if (pend_q && wr_if.ready) begin
      pend_d = 1'b0;
    end
    if (new_wr) begin
      if (pend_d) begin
        ovr_d = 1'b1;
      end else begin
        pend_d   = 1'b1;
        pend_a_d = sync_mode ? pin_addr : addr_d;
        pend_w_d = pin_data;
      end
    end
  end

  // Reset clears the held word so no write survives it
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_q   <= 1'b0;
      pend_a_q <= '0;
      pend_w_q <= '0;
      ovr_q    <= 1'b0;
    end else begin
      pend_q   <= pend_d;
      pend_a_q <= pend_a_d;
      pend_w_q <= pend_w_d;
      ovr_q    <= ovr_d;
    end
  end

  assign wr_if.valid = pend_q;
  assign wr_if.addr  = pend_a_q;
  assign wr_if.data  = pend_w_q;

  write_buffer write_buffer_inst (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .push      (wr_if.snk),
    .valid_out (wr_valid_out),
    .addr_out  (wr_addr_out),
    .data_out  (wr_data_out),
    .ready_in  (wr_ready_in)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign dq_out              = dq_q;
  assign dq_oe_out           = dq_oe_q;
  assign wait_out            = wait_q;
  assign wait_oe_out         = wait_oe_q;
  assign read_config_reg_out = cfg_q;
  assign array_addr_out      = addr_q;
  assign upper_die_out       = die_q;
  assign array_active_out    = active_q;
  assign overrun_out         = ovr_q;

endmodule // flash_host_bus_interface

/* File: flash_bus_pkg.sv */
package flash_bus_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 25;   // Word address pins 25 down to 1
  localparam int DATA_W = 16;
  localparam int CFG_W  = 16;

  // ****************************************
  // Pin vector layout after synchronising
  // ****************************************
  localparam int PIN_W    = ADDR_W + DATA_W + 5;
  localparam int P_CLK    = 0;
  localparam int P_AVALID = 1;
  localparam int P_WE     = 2;
  localparam int P_OE     = 3;
  localparam int P_CS     = 4;
  localparam int P_DQ_LO  = 5;
  localparam int P_ADR_LO = P_DQ_LO + DATA_W;
  // Controls idle high, address valid idle low so addresses flow
  localparam logic [PIN_W-1:0] PIN_RESET = 46'h00000000001c;

  // ****************************************
  // Density selection and address masks
  // ****************************************
  typedef enum logic [1:0] {
    DENS_64M,
    DENS_128M,
    DENS_256M,
    DENS_512M
  } density_t;

  localparam logic [ADDR_W-1:0] MASK_64M  = 25'h03fffff;
  localparam logic [ADDR_W-1:0] MASK_128M = 25'h07fffff;
  localparam logic [ADDR_W-1:0] MASK_256M = 25'h0ffffff;
  localparam logic [ADDR_W-1:0] MASK_512M = 25'h1ffffff;
  localparam int DIE_BIT = ADDR_W - 1;   // Top address pin

  // ****************************************
  // Read configuration
  // ****************************************
  localparam int CFG_WAIT_POL_BIT = 10;  // 1: wait asserted high
  localparam int CFG_SYNC_BIT     = 15;  // 1: synchronous reads
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0400;

endpackage

/* File: wr_stream_if.sv */
`timescale 1ns/1ns
interface wr_stream_if;
  import flash_bus_pkg::*;
  logic              valid;
  logic              ready;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;

  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface

/* File: write_buffer.sv */
`timescale 1ns/1ns
module write_buffer
  import flash_bus_pkg::*;
(
  input  wire logic              clock_in,    // System clock
  input  wire logic              rstn_in,     // Async reset, low
  wr_stream_if.snk               push,        // Captured writes
  output logic                   valid_out,   // Head entry valid
  output logic [ADDR_W-1:0]      addr_out,    // Head address
  output logic [DATA_W-1:0]      data_out,    // Head data
  input  wire logic              ready_in     // Drain accepts head
);

  logic              head_v_q, head_v_d;
  logic              tail_v_q, tail_v_d;
  logic [ADDR_W-1:0] head_a_q, head_a_d, tail_a_q, tail_a_d;
  logic [DATA_W-1:0] head_w_q, head_w_d, tail_w_q, tail_w_d;
  logic              pop, psh;

  // Head always sits in the first entry so outputs come from flops
  assign push.ready = !tail_v_q;
  assign valid_out  = head_v_q;
  assign addr_out   = head_a_q;
  assign data_out   = head_w_q;

  // ****************************************
  // Next state of the two entries
  // ****************************************
  always_comb begin
    pop      = head_v_q && ready_in;
    psh      = push.valid && !tail_v_q;
    head_v_d = head_v_q;
    head_a_d = head_a_q;
    head_w_d = head_w_q;
    tail_v_d = tail_v_q;
    tail_a_d = tail_a_q;
    tail_w_d = tail_w_q;
    if (pop) begin
      head_v_d = tail_v_q;
      head_a_d = tail_a_q;
      head_w_d = tail_w_q;
      tail_v_d = 1'b0;
    end
    if (psh) begin
      // New word goes behind whatever stays in the head
      if (!head_v_d) begin
        head_v_d = 1'b1;
        head_a_d = push.addr;
        head_w_d = push.data;
      end else begin
        tail_v_d = 1'b1;
        tail_a_d = push.addr;
        tail_w_d = push.data;
      end
    end
  end

  // Register the entries
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_a_q <= '0;
      tail_a_q <= '0;
      head_w_q <= '0;
      tail_w_q <= '0;
    end else begin
      head_v_q <= head_v_d;
      tail_v_q <= tail_v_d;
      head_a_q <= head_a_d;
      tail_a_q <= tail_a_d;
      head_w_q <= head_w_d;
      tail_w_q <= tail_w_d;
    end
  end

endmodule // write_buffer

/* File: flash_bus_properties.sv */
`timescale 1ns/1ns
module flash_bus_properties
  import flash_bus_pkg::*;
(
  input wire logic              clock_in,            // Clock
  input wire logic              rstn_in,             // Reset
  input wire logic [ADDR_W-1:0] addr_pin_in,         // Address
  input wire logic              chip_sel_n_in,       // Select
  input wire logic              out_en_n_in,         // Enable
  input wire logic              write_en_n_in,       // Strobe
  input wire logic              address_valid_n_in,  // Valid
  input wire logic [1:0]        density_in,          // Density
  input wire logic [CFG_W-1:0]  read_config_reg_out, // Config
  input wire logic [DATA_W-1:0] dq_oe_out,           // Drive
  input wire logic              wait_out,            // Wait
  input wire logic              wait_oe_out,         // Wait drive
  input wire logic [ADDR_W-1:0] array_addr_out,      // Array address
  input wire logic              upper_die_out,       // Die
  input wire logic              array_active_out,    // Active
  input wire logic              wr_ready_in,         // Core ready
  input wire logic              wr_valid_out         // Word ready
);
  // ****************
  // Pin checks
  // ****************
  // Eight samples cover the pin filter plus the output register
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  property p_drive;
    (!chip_sel_n_in && !out_en_n_in && write_en_n_in)[*8]
      |-> dq_oe_out == '1 && wait_oe_out;
  endproperty
  a_drive: assert property (p_drive) else $error("no drive");

  property p_oe_off;
    out_en_n_in[*8] |-> dq_oe_out == '0 && !wait_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe leak");

  property p_cs_off;
    chip_sel_n_in[*8] |-> dq_oe_out == '0 && !wait_oe_out && !array_active_out;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("cs leak");

  property p_active;
    (!chip_sel_n_in)[*8] |-> array_active_out;
  endproperty
  a_active: assert property (p_active) else $error("inactive");

  property p_flow;
    (!address_valid_n_in && $stable(addr_pin_in) && density_in == 2'd3 &&
     !read_config_reg_out[15])[*8] |-> array_addr_out == addr_pin_in;
  endproperty
  a_flow: assert property (p_flow) else $error("no flow");

  property p_mask;
    (density_in == 2'd0)[*4] |-> array_addr_out[24:22] == 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("bits high");

  property p_die;
    (density_in != 2'd3)[*4] |-> !upper_die_out;
  endproperty
  a_die: assert property (p_die) else $error("die set");

  property p_wait;
    (!read_config_reg_out[15] && $stable(read_config_reg_out))[*2] ##0
      wait_oe_out |-> wait_out == !read_config_reg_out[10];
  endproperty
  a_wait: assert property (p_wait) else $error("wait set");

  property p_wr;
    $rose(write_en_n_in) && !chip_sel_n_in && wr_ready_in && !wr_valid_out
      |-> ##[3:10] wr_valid_out;
  endproperty
  a_wr: assert property (p_wr) else $error("no word");

  // Main traffic kinds seen at least once
  c_read: cover property (dq_oe_out == '1);
  c_word: cover property (wr_valid_out && wr_ready_in);
  c_sync: cover property (read_config_reg_out[15] && wait_oe_out);
endmodule // flash_bus_properties

bind flash_host_bus_interface flash_bus_properties flash_bus_properties_inst (
  .clock_in, .rstn_in, .addr_pin_in, .chip_sel_n_in, .out_en_n_in,
  .write_en_n_in, .address_valid_n_in, .density_in, .read_config_reg_out,
  .dq_oe_out, .wait_out, .wait_oe_out, .array_addr_out, .upper_die_out,
  .array_active_out, .wr_ready_in, .wr_valid_out
);

/* File: host_bus_model.sv */
`timescale 1ns/1ns
module host_bus_model
  import flash_bus_pkg::*;
(
  input  wire logic              clock_in,  // System clock
  input  wire logic [DATA_W-1:0] dq_in,     // Device value
  input  wire logic [DATA_W-1:0] dq_oe_in,  // Device enable
  output logic      [DATA_W-1:0] dq_out,    // Wire level
  output logic      [ADDR_W-1:0] addr_out,  // Address
  output logic                   cs_n_out,  // Select
  output logic                   oe_n_out,  // Output enable
  output logic                   we_n_out,  // Strobe
  output logic                   avalid_n_out, // Address valid
  output logic                   bclk_out   // Bus clock
);
  // ****************
  // Host controller
  // ****************
  logic [DATA_W-1:0] hdq;
  logic              hoe;

  // Idle: deselected, valid parked low, bus clock tied low
  initial begin
    addr_out  = '0;
    hdq       = '0;
    hoe       = 1'b0;
    cs_n_out  = 1'b1;
    oe_n_out  = 1'b1;
    we_n_out  = 1'b1;
    avalid_n_out = 1'b0;
    bclk_out  = 1'b0;
  end

  // No pull: a released wire shows the inverse, never stale data
  assign dq_out = (dq_oe_in & dq_in) | (~dq_oe_in & (hoe ? hdq : ~dq_in));

  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Pins rest eight clocks so the device filter passes them
  task automatic set_pins(input logic cs, oe, av,
                          input logic [ADDR_W-1:0] a);
    cs_n_out  = cs;
    oe_n_out  = oe;
    avalid_n_out = av;
    addr_out  = a;
    hold(8);
  endtask

  // Strobe low then high six clocks each, data held past the rise
  task automatic write_word(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d);
    addr_out = a;
    hdq      = d;
    hoe      = 1'b1;
    cs_n_out = 1'b0;
    we_n_out = 1'b0;
    hold(6);
    we_n_out = 1'b1;
    hold(6);
    hoe      = 1'b0;
    cs_n_out = 1'b1;
    hold(1);
  endtask

  // Bus clock pulse, also sent in async mode where no capture follows
  task automatic clk_pulse();
    bclk_out = 1'b1;
    hold(4);
    bclk_out = 1'b0;
    hold(8);
  endtask
endmodule // host_bus_model

/* File: tb_flash_host_bus_interface.sv */
`timescale 1ns/1ns
module tb_flash_host_bus_interface;
  import flash_bus_pkg::*;
  // ****************
  // Bench
  // ****************
  logic              clock_in, rstn_in, chip_sel_n_in, out_en_n_in;
  logic              write_en_n_in, address_valid_n_in, bus_clk_in;
  logic              wait_out, wait_oe_out, cfg_load_in, upper_die_out;
  logic              array_active_out, rd_valid_in, wr_valid_out;
  logic              wr_ready_in, overrun_clr_in, overrun_out;
  logic [1:0]        density_in;
  logic [ADDR_W-1:0] addr_pin_in, array_addr_out, wr_addr_out;
  logic [DATA_W-1:0] dq_in, dq_out, dq_oe_out, rd_data_in, wr_data_out;
  logic [CFG_W-1:0]  cfg_data_in, read_config_reg_out;
  logic [ADDR_W-1:0] masks [4];
  int                n_errors, n_tests;

  flash_host_bus_interface flash_host_bus_interface_inst (
    .clock_in, .rstn_in, .addr_pin_in, .dq_in, .dq_out, .dq_oe_out,
    .chip_sel_n_in, .out_en_n_in, .write_en_n_in, .address_valid_n_in,
    .bus_clk_in, .wait_out, .wait_oe_out, .density_in, .cfg_load_in,
    .cfg_data_in, .read_config_reg_out, .array_addr_out, .upper_die_out,
    .array_active_out, .rd_data_in, .rd_valid_in, .wr_valid_out,
    .wr_addr_out, .wr_data_out, .wr_ready_in, .overrun_clr_in, .overrun_out
  );
  host_bus_model host_bus_model_inst (
    .clock_in, .dq_in(dq_out), .dq_oe_in(dq_oe_out), .dq_out(dq_in),
    .addr_out(addr_pin_in), .cs_n_out(chip_sel_n_in),
    .oe_n_out(out_en_n_in), .we_n_out(write_en_n_in),
    .avalid_n_out(address_valid_n_in), .bclk_out(bus_clk_in)
  );

  // 100 ns clock
  always #50 clock_in = ~clock_in;

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic pins(input logic cs, oe, av, input logic [ADDR_W-1:0] a);
    host_bus_model_inst.set_pins(cs, oe, av, a);
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Config pulse is one cycle wide
  task automatic load(input logic [CFG_W-1:0] v);
    cfg_data_in = v;
    cfg_load_in = 1'b1;
    tick(1);
    cfg_load_in = 1'b0;
    tick(2);
    chk("config", v, read_config_reg_out);
  endtask

  task automatic t_reset();
    chk("dq_oe", 0, dq_oe_out);
    chk("wait_oe", 0, wait_oe_out);
    chk("config", CFG_RESET, read_config_reg_out);
    $display("reset done");
  endtask

  task automatic t_addr();
    foreach (masks[d]) begin
      density_in = 2'(d);
      pins(1, 1, 0, '1);
      chk("addr", masks[d], array_addr_out);
      chk("die", d == 3, upper_die_out);
    end
    density_in = 2'd0;
    pins(1, 1, 0, 25'h1);
    chk("addr", 1, array_addr_out);
    density_in = 2'd3;
    pins(1, 1, 0, 25'h0123456);
    chk("flow", 25'h0123456, array_addr_out);
    pins(1, 1, 1, 25'h0123456);
    pins(1, 1, 1, 25'h1abcdef);
    chk("latch", 25'h0123456, array_addr_out);
    host_bus_model_inst.clk_pulse();
    chk("async clk", 25'h0123456, array_addr_out);
    load(16'h8400);
    pins(1, 1, 0, 25'h0aaaaaa);
    host_bus_model_inst.clk_pulse();
    pins(1, 1, 0, 25'h1555555);
    chk("clk cap", 25'h0aaaaaa, array_addr_out);
    pins(1, 1, 1, 25'h1555555);
    pins(1, 1, 0, 25'h0333333);
    pins(1, 1, 1, 25'h0333333);
    pins(1, 1, 1, 25'h1000000);
    chk("adv cap", 25'h0333333, array_addr_out);
    load(16'h0400);
    pins(1, 1, 0, 25'h0000042);
    $display("address done");
  endtask

  task automatic t_read();
    rd_data_in = 16'ha5c3;
    rd_valid_in = 1'b1;
    pins(0, 0, 0, 25'h0000042);
    chk("dq_oe", 16'hffff, dq_oe_out);
    chk("dq", 16'ha5c3, dq_out);
    chk("wait", 0, wait_out);
    chk("active", 1, array_active_out);
    pins(0, 1, 0, 25'h0000042);
    chk("dq_oe", 0, dq_oe_out);
    chk("wait_oe", 0, wait_oe_out);
    pins(0, 0, 0, 25'h0000042);
    pins(1, 0, 0, 25'h0000042);
    chk("dq_oe", 0, dq_oe_out);
    chk("active", 0, array_active_out);
    chk("wait_oe", 0, wait_oe_out);
    $display("read done");
  endtask

  // Sync read: wait follows read data validity in both polarities
  task automatic t_wait();
    load(16'h8400);
    rd_valid_in = 1'b0;
    pins(0, 0, 0, 25'h0000042);
    chk("wait", 1, wait_out);
    rd_valid_in = 1'b1;
    tick(3);
    chk("wait", 0, wait_out);
    load(16'h8000);
    chk("wait", 1, wait_out);
    rd_valid_in = 1'b0;
    tick(3);
    chk("wait", 0, wait_out);
    pins(1, 1, 0, 25'h0000042);
    load(16'h0400);
    $display("wait done");
  endtask

  // Core stalls: three words fit, the fourth is refused
  task automatic t_write();
    int k;
    for (int i = 0; i < 4; i++) begin
      host_bus_model_inst.write_word(25'(256 + i), {4{4'(i + 1)}});
    end
    tick(8);
    chk("overrun", 1, overrun_out);
    for (int i = 0; i < 3; i++) begin
      k = 0;
      while (wr_valid_out !== 1'b1 && k < 20) begin
        tick(1);
        k++;
      end
      if (k == 20) begin
        n_errors++;
        $display("mismatch wr_valid expected 1 seen %b", wr_valid_out);
        close_out();
      end
      chk("wr_addr", 256 + i, wr_addr_out);
      chk("wr_data", {4{4'(i + 1)}}, wr_data_out);
      wr_ready_in = 1'b1;
      tick(1);
      wr_ready_in = 1'b0;
      tick(1);
    end
    tick(4);
    chk("wr_valid", 0, wr_valid_out);
    overrun_clr_in = 1'b1;
    tick(1);
    overrun_clr_in = 1'b0;
    wr_ready_in = 1'b1;
    tick(1);
    chk("overrun", 0, overrun_out);
    host_bus_model_inst.write_word(25'h0000200, 16'h5a5a);
    tick(8);
    $display("write done");
  endtask

  // Reset held four cycles, then each scenario in turn
  initial begin
    clock_in = 1'b0;
    rstn_in = 1'b0;
    {density_in, cfg_load_in, cfg_data_in, rd_data_in} = '0;
    {rd_valid_in, wr_ready_in, overrun_clr_in} = '0;
    masks = '{MASK_64M, MASK_128M, MASK_256M, MASK_512M};
    n_errors = 0;
    n_tests = 0;
    tick(4);
    rstn_in = 1'b1;
    tick(1);
    t_reset();
    t_addr();
    t_read();
    t_wait();
    t_write();
    close_out();
  end
endmodule // tb_flash_host_bus_interface
